// ---- upt_core.sv ----
// full-duplex uart core with parity, axi4-lite register slave and baud tick timing
// Notes on behaviour
// - even parity: bit set for odd ones
// - even parity rx: odd total means error
// - odd parity: bit clear for odd ones
// - odd parity rx: even total means error
// - zero parity sends zero, never checks
// - no parity: no bit, no error
// - power idles line high; write starts frame
// - start moves buffer into shift register
// - done pulse right after last stop bit
// - no pending data keeps line idle
// - buffer accepts next once shifting began
// - buffer full flag in status bit 1
// - shift busy flag in status bit 0
// - flags step 10, then 01; 11 only on a write while shifting
// - receiver samples only when powered, enabled
// - falling edge starts counter, resample start
// - stop bit raises done, loads buffer unless overrun
// - parity error reported at frame end
// - receiver checks only one stop bit
// - frame start, 7/8 data, parity, 1/2 stop
// - bit order and output inversion selectable
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`include "upt_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module upt_core
    import upt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic baud_tick,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic tx_done_irq,
    output logic rx_done_irq,
    output logic rx_error_irq
);
    logic [7:0] mode_ff, ctrl_ff, baud_ff, tx_buffer_ff, rx_buffer_ff, rx_err_ff;
    logic [4:0] awaddr_ff, araddr_ff;
    logic aw_ff, w_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_wr, do_rd, wr_txbuf, rd_rxerr, rd_rxbuf;
    logic power, tx_en, rx_en, char8, stop2, msb_first, invert;
    upt_par_e par_mode;

    assign power = mode_ff[`UPT_BIT_POWER];
    assign tx_en = power & mode_ff[`UPT_BIT_TXE];
    assign rx_en = power & mode_ff[`UPT_BIT_RXE];
    assign par_mode = upt_par_e'(mode_ff[`UPT_BIT_PS1:`UPT_BIT_PS0]);
    assign char8 = mode_ff[`UPT_BIT_CL];
    assign stop2 = mode_ff[`UPT_BIT_SL];
    assign msb_first = ctrl_ff[`UPT_BIT_DIR];
    assign invert = ctrl_ff[`UPT_BIT_INV];

    // write channel: address and data latched independently, either order
    assign s_axi_awready = ~aw_ff & ~s_axi_bvalid;
    assign s_axi_wready = ~w_ff & ~s_axi_bvalid;
    assign do_wr = aw_ff & w_ff & ~s_axi_bvalid;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 5'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UPT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_ff <= `UPT_OFS_RXBUF && awaddr_ff[1:0] == 2'b00) ?
                    `UPT_RESP_OKAY : `UPT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_rd = s_axi_arvalid & s_axi_arready;
    assign rd_rxerr = do_rd && s_axi_araddr == `UPT_OFS_RXERR;
    assign rd_rxbuf = do_rd && s_axi_araddr == `UPT_OFS_RXBUF;
    logic [7:0] tx_status;
    logic [7:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            5'(`UPT_OFS_MODE): rd_mux = mode_ff;
            5'(`UPT_OFS_CTRL): rd_mux = ctrl_ff;
            5'(`UPT_OFS_BAUD): rd_mux = baud_ff;
            5'(`UPT_OFS_TXBUF): rd_mux = tx_buffer_ff;
            `UPT_OFS_TXSTAT: rd_mux = tx_status;
            `UPT_OFS_RXERR: rd_mux = rx_err_ff;
            `UPT_OFS_RXBUF: rd_mux = rx_buffer_ff;
            default: rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UPT_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_mux};
            s_axi_rresp <= (s_axi_araddr <= `UPT_OFS_RXBUF && s_axi_araddr[1:0] == 2'b00) ?
                `UPT_RESP_OKAY : `UPT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // configuration registers, low byte lane only
    assign wr_txbuf = do_wr && awaddr_ff == `UPT_OFS_TXBUF && wstrb_ff[0] && tx_en;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_ff <= `UPT_MODE_RESET;
            ctrl_ff <= `UPT_CTRL_RESET;
            baud_ff <= `UPT_BAUD_RESET;
        end else if (do_wr && wstrb_ff[0]) begin
            if (awaddr_ff == `UPT_OFS_MODE) mode_ff <= wdata_ff[7:0];
            if (awaddr_ff == `UPT_OFS_CTRL) ctrl_ff <= wdata_ff[7:0];
            if (awaddr_ff == `UPT_OFS_BAUD) baud_ff <= wdata_ff[7:0];
        end
    end

    // ---------------- transmitter ----------------
    upt_state_e tx_st_ff;
    logic [7:0] tx_shift_reg_ff;
    logic [2:0] tx_cnt_ff;
    logic tx_full_ff, tx_par_ff, tx_line_ff, tx_load;
    logic [2:0] last_bit;
    assign last_bit = char8 ? 3'd7 : 3'd6;
    assign tx_load = tx_st_ff == UPT_S_IDLE && tx_full_ff && tx_en;
    assign tx_status = {6'h00, tx_full_ff, tx_st_ff != UPT_S_IDLE};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_buffer_ff <= 8'h00;
            tx_full_ff <= 1'b0;
        end else if (!tx_en) begin
            tx_full_ff <= 1'b0;
        end else if (wr_txbuf) begin
            tx_buffer_ff <= wdata_ff[7:0];
            tx_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_full_ff <= 1'b0;
        end
    end

    // a frame starts only from a loaded buffer, so the line idles otherwise
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_ff <= UPT_S_IDLE;
            tx_shift_reg_ff <= 8'h00;
            tx_cnt_ff <= 3'd0;
            tx_par_ff <= 1'b0;
            tx_line_ff <= 1'b1;
            tx_done_irq <= 1'b0;
        end else begin
            tx_done_irq <= 1'b0;
            if (!tx_en) begin
                tx_st_ff <= UPT_S_IDLE;
                tx_line_ff <= 1'b1;
            end else begin
                case (tx_st_ff)
                    UPT_S_IDLE: if (tx_load) begin
                        tx_shift_reg_ff <= msb_first ?
                            (char8 ? tx_buffer_ff : {tx_buffer_ff[6:0], 1'b0}) :
                            tx_buffer_ff;
                        tx_par_ff <= par_mode == UPT_PAR_EVEN ? ^tx_buffer_ff[6:0] ^
                            (char8 & tx_buffer_ff[7]) : ~(^tx_buffer_ff[6:0] ^
                            (char8 & tx_buffer_ff[7]));
                        tx_st_ff <= UPT_S_START;
                    end
                    UPT_S_START: if (baud_tick) begin
                        tx_line_ff <= 1'b0;
                        tx_cnt_ff <= 3'd0;
                        tx_st_ff <= UPT_S_DATA;
                    end
                    UPT_S_DATA: if (baud_tick) begin
                        tx_line_ff <= msb_first ? tx_shift_reg_ff[7] : tx_shift_reg_ff[0];
                        tx_shift_reg_ff <= msb_first ? {tx_shift_reg_ff[6:0], 1'b0} :
                            {1'b0, tx_shift_reg_ff[7:1]};
                        tx_cnt_ff <= tx_cnt_ff + 3'd1;
                        if (tx_cnt_ff == last_bit)
                            tx_st_ff <= par_mode == UPT_PAR_NONE ? UPT_S_STOP : UPT_S_PAR;
                    end
                    UPT_S_PAR: if (baud_tick) begin
                        tx_line_ff <= par_mode == UPT_PAR_ZERO ? 1'b0 : tx_par_ff;
                        tx_st_ff <= UPT_S_STOP;
                    end
                    UPT_S_STOP: if (baud_tick) begin
                        tx_line_ff <= 1'b1;
                        tx_st_ff <= UPT_S_STOP2;
                        tx_cnt_ff <= stop2 ? 3'd1 : 3'd0;
                    end
                    UPT_S_STOP2: if (baud_tick) begin
                        if (tx_cnt_ff == 3'd0) begin
                            tx_done_irq <= 1'b1;
                            tx_st_ff <= UPT_S_IDLE;
                        end else begin
                            tx_cnt_ff <= 3'd0;
                        end
                    end
                    default: tx_st_ff <= UPT_S_IDLE;
                endcase
            end
        end
    end
    assign serial_out_pin = power ? (tx_line_ff ^ invert) : 1'b1;

    // ---------------- receiver ----------------
    upt_state_e rx_st_ff;
    logic [7:0] rx_shift_reg_ff, rx_cnt_div_ff;
    logic [2:0] rx_bits_ff;
    logic rx_in, rx_prev_ff, rx_par_ff, rx_samp, rx_full_ff;
    assign rx_in = rx_en ? serial_in_pin : 1'b1;
    // resample point: divisor counted in baud ticks, one bit time per sample
    assign rx_samp = baud_tick && rx_cnt_div_ff == baud_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_ff <= UPT_S_IDLE;
            rx_prev_ff <= 1'b1;
            rx_cnt_div_ff <= 8'h00;
            rx_shift_reg_ff <= 8'h00;
            rx_bits_ff <= 3'd0;
            rx_par_ff <= 1'b0;
            rx_buffer_ff <= `UPT_RXBUF_RESET;
            rx_err_ff <= 8'h00;
            rx_done_irq <= 1'b0;
            rx_error_irq <= 1'b0;
        end else begin
            rx_done_irq <= 1'b0;
            rx_error_irq <= 1'b0;
            rx_prev_ff <= rx_in;
            if (rd_rxerr) rx_err_ff <= 8'h00;
            if (!power) begin
                rx_buffer_ff <= `UPT_RXBUF_RESET;
                rx_err_ff <= 8'h00;
            end
            if (baud_tick) rx_cnt_div_ff <= rx_samp ? 8'h00 : rx_cnt_div_ff + 8'h01;
            if (!rx_en) begin
                rx_st_ff <= UPT_S_IDLE;
            end else begin
                case (rx_st_ff)
                    UPT_S_IDLE: if (rx_prev_ff && !rx_in) begin
                        rx_cnt_div_ff <= 8'h00;
                        rx_st_ff <= UPT_S_START;
                    end
                    UPT_S_START: if (rx_samp) begin
                        rx_bits_ff <= 3'd0;
                        rx_par_ff <= 1'b0;
                        rx_st_ff <= rx_in ? UPT_S_IDLE : UPT_S_DATA;
                    end
                    UPT_S_DATA: if (rx_samp) begin
                        rx_shift_reg_ff <= msb_first ? {rx_shift_reg_ff[6:0], rx_in} :
                            {rx_in, rx_shift_reg_ff[7:1]};
                        rx_par_ff <= rx_par_ff ^ rx_in;
                        rx_bits_ff <= rx_bits_ff + 3'd1;
                        if (rx_bits_ff == last_bit)
                            rx_st_ff <= par_mode == UPT_PAR_NONE ? UPT_S_STOP : UPT_S_PAR;
                    end
                    UPT_S_PAR: if (rx_samp) begin
                        rx_par_ff <= rx_par_ff ^ rx_in;
                        rx_st_ff <= UPT_S_STOP;
                    end
                    UPT_S_STOP: if (rx_samp) begin
                        rx_st_ff <= UPT_S_IDLE;
                        rx_done_irq <= 1'b1;
                        if (!rx_err_ff[`UPT_BIT_OVERRUN] && !rx_full_ff)
                            rx_buffer_ff <= char8 || msb_first ? rx_shift_reg_ff :
                                {1'b0, rx_shift_reg_ff[7:1]};
                        rx_err_ff[`UPT_BIT_OVERRUN] <= rx_full_ff;
                        rx_err_ff[`UPT_BIT_FRAME_ERR] <= ~rx_in;
                        rx_err_ff[`UPT_BIT_PARITY_ERR] <=
                            (par_mode == UPT_PAR_EVEN && rx_par_ff) ||
                            (par_mode == UPT_PAR_ODD && !rx_par_ff);
                        rx_error_irq <= rx_full_ff || !rx_in ||
                            (par_mode == UPT_PAR_EVEN && rx_par_ff) ||
                            (par_mode == UPT_PAR_ODD && !rx_par_ff);
                    end
                    default: rx_st_ff <= UPT_S_IDLE;
                endcase
            end
        end
    end

    // unread flag: set by a new character wins over a simultaneous read
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) rx_full_ff <= 1'b0;
        else if (rx_done_irq && !rx_err_ff[`UPT_BIT_OVERRUN]) rx_full_ff <= 1'b1;
        else if (rd_rxbuf || !power) rx_full_ff <= 1'b0;
    end

    // assertions
    a_load_clears_full: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_load |=> !tx_full_ff || $past(wr_txbuf)) else $error("buffer not taken");
    a_status_busy: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_load |=> tx_status[`UPT_BIT_SHIFT_BUSY]) else $error("busy not set");
    a_status_full: assert property (@(posedge ref_clk) disable iff (!rstn)
        wr_txbuf |=> tx_status[`UPT_BIT_BUF_FULL]) else $error("full not set");
    a_done_line_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_done_irq |-> tx_line_ff && tx_st_ff == UPT_S_IDLE) else $error("bad done");
    a_idle_high: assert property (@(posedge ref_clk) disable iff (!rstn)
        !tx_en |=> serial_out_pin == (power ? ~invert : 1'b1)) else $error("line not idle");
    a_idle_stays: assert property (@(posedge ref_clk) disable iff (!rstn)
        tx_st_ff == UPT_S_IDLE && !tx_full_ff |=> tx_st_ff == UPT_S_IDLE) else $error("spurious");
    a_zero_par_noerr: assert property (@(posedge ref_clk) disable iff (!rstn)
        rx_done_irq && par_mode inside {UPT_PAR_ZERO, UPT_PAR_NONE} |->
        !rx_err_ff[`UPT_BIT_PARITY_ERR]) else $error("parity err in zero/none");
    a_rx_disabled: assert property (@(posedge ref_clk) disable iff (!rstn)
        !rx_en |=> rx_st_ff == UPT_S_IDLE) else $error("rx ran disabled");
    // a write into an empty, idle transmitter must show 10 before 01
    sequence s_first_write;
        wr_txbuf && tx_st_ff == UPT_S_IDLE && !tx_full_ff;
    endsequence
    sequence s_flags_10_01;
        tx_status[1:0] == 2'b10 ##1 tx_status[1:0] == 2'b01;
    endsequence
    a_flags_first_step: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_first_write |=> s_flags_10_01) else $error("flags skipped a step");
endmodule
`default_nettype wire

// ---- upt_core_bench.sv ----
// self-checking bench for the uart core with its register bus
`timescale 1ns/100ps
`default_nettype none
`include "upt_defs.svh"
module upt_core_bench import upt_pkg::*;;
    logic ref_clk, rstn, baud_tick, serial_in_pin, serial_out_pin;
    logic tx_done_irq, rx_done_irq, rx_error_irq;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_errors = 0, compares = 0, n_txd = 0, n_rxd = 0, n_rxe = 0, tcnt = 0;
    upt_core upt_core_i (.ref_clk, .rstn, .baud_tick, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .serial_in_pin, .serial_out_pin, .tx_done_irq, .rx_done_irq, .rx_error_irq);
    upt_remote upt_remote_i (.ref_clk, .baud_tick, .line_in(serial_out_pin),
        .line_out(serial_in_pin));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // one tick every 16 clocks; pulses are counted here, the scenarios compare counts
    always @(posedge ref_clk) begin
        tcnt <= (tcnt + 1) % 16;
        baud_tick <= (tcnt == 15);
        n_txd <= n_txd + int'(tx_done_irq === 1'b1);
        n_rxd <= n_rxd + int'(rx_done_irq === 1'b1);
        n_rxe <= n_rxe + int'(rx_error_irq === 1'b1);
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bready and rready stay high, so no handshake signal is lowered and raised at one edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        resp = s_axi_bresp;
        if (n == 50) check("write answer", 1, 0);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (n == 50) check("read answer", 1, 0);
    endtask
    task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        check(nm, e, v);
    endtask
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [1:0] p,
            input logic c8, input logic s2, input logic msb, output int len);
        logic [11:0] f;
        logic x;
        int n;
        n = c8 ? 8 : 7;
        f = 12'hFFF;
        x = 1'b0;
        for (int i = 0; i < n; i++) begin
            f[i] = msb ? d[n-1-i] : d[i];
            x ^= d[i];
        end
        len = n + 1 + int'(s2);
        if (p != UPT_PAR_NONE) begin
            f[n] = (p == UPT_PAR_EVEN) ? x : (p == UPT_PAR_ODD) ? !x : 1'b0;
            len++;
        end
        return f;
    endfunction
    // power first, enables after
    task automatic cfg(input logic [1:0] p, input logic c8, input logic s2, input logic rxe);
        wr(`UPT_OFS_MODE, 8'h80);
        wr(`UPT_OFS_MODE, {2'b11, rxe, p, c8, s2, 1'b0});
    endtask
    task automatic wait_idle(output logic saw11);
        logic [31:0] v;
        saw11 = 1'b0;
        for (int i = 0; i < 500; i++) begin
            rd(`UPT_OFS_TXSTAT, v);
            if (v[1:0] === 2'b11) saw11 = 1'b1;
            if (v === 0) break;
        end
        check("tx status", 0, v);
    endtask
    task automatic tx_one(input logic [7:0] d, input logic [1:0] p, input logic c8,
            input logic s2, input logic msb);
        logic [11:0] f;
        logic s;
        int len, n0;
        f = frame(d, p, c8, s2, msb, len);
        upt_remote_i.rx_len = len;
        n0 = n_txd;
        cfg(p, c8, s2, 1'b0);
        wr(`UPT_OFS_CTRL, {6'h00, msb, 1'b0});
        rdc("free before write", `UPT_OFS_TXSTAT, 0);
        wr(`UPT_OFS_TXBUF, d);
        wait_idle(s);
        check("tx frames", 1, upt_remote_i.rx_q.size());
        if (upt_remote_i.rx_q.size() > 0) check("tx frame", f, upt_remote_i.rx_q.pop_front());
        check("tx done", n0 + 1, n_txd);
    endtask
    task automatic t_reset();
        check("idle line", 1, serial_out_pin);
        rdc("mode", `UPT_OFS_MODE, 8'h01);
        rdc("baud", `UPT_OFS_BAUD, 8'hFF);
        rdc("rx buf", `UPT_OFS_RXBUF, 8'hFF);
        rdc("status", `UPT_OFS_TXSTAT, 8'h00);
        rdc("unmapped", 5'h1C, 0);
        check("unmapped resp", `UPT_RESP_SLVERR, resp);
        wr(`UPT_OFS_BAUD, 8'h00);
        check("write resp", `UPT_RESP_OKAY, resp);
        wr(`UPT_OFS_TXBUF, 8'hA5);
        repeat (300) @(posedge ref_clk);
        check("unpowered send", 0, upt_remote_i.rx_q.size());
    endtask
    task automatic t_tx();
        for (int p = 0; p < 4; p++) begin
            tx_one(8'h55, p[1:0], 1'b1, 1'b0, 1'b0);
            tx_one(8'h07, p[1:0], 1'b1, 1'b0, 1'b0);
        end
        tx_one(8'h36, UPT_PAR_ODD, 1'b0, 1'b1, 1'b0);
        tx_one(8'hA1, UPT_PAR_EVEN, 1'b1, 1'b0, 1'b1);
        wr(`UPT_OFS_CTRL, 8'h01);
        check("inverted idle", 0, serial_out_pin);
        wr(`UPT_OFS_CTRL, 8'h00);
        repeat (300) @(posedge ref_clk);
        upt_remote_i.rx_q.delete();
    endtask
    task automatic t_b2b();
        logic [11:0] f1, f2;
        logic [31:0] v;
        logic s;
        int len, n0;
        f1 = frame(8'h31, UPT_PAR_EVEN, 1'b1, 1'b0, 1'b0, len);
        f2 = frame(8'hC4, UPT_PAR_EVEN, 1'b1, 1'b0, 1'b0, len);
        upt_remote_i.rx_len = len;
        n0 = n_txd;
        cfg(UPT_PAR_EVEN, 1'b1, 1'b0, 1'b0);
        wr(`UPT_OFS_TXBUF, 8'h31);
        for (int i = 0; i < 300; i++) begin
            rd(`UPT_OFS_TXSTAT, v);
            if (v[1] === 1'b0) break;
        end
        check("shifting", 2'b01, v[1:0]);
        wr(`UPT_OFS_TXBUF, 8'hC4);
        wait_idle(s);
        check("both flags", 1, s);
        check("b2b frames", 2, upt_remote_i.rx_q.size());
        if (upt_remote_i.rx_q.size() == 2) begin
            check("first", f1, upt_remote_i.rx_q.pop_front());
            check("second", f2, upt_remote_i.rx_q.pop_front());
        end
        check("b2b done", n0 + 2, n_txd);
        repeat (400) @(posedge ref_clk);
        check("stays idle", 0, upt_remote_i.rx_q.size());
    endtask
    task automatic rx_one(input logic [7:0] d, input logic [1:0] p, input logic bad,
            input logic rxe, input logic [7:0] eb);
        logic [11:0] f;
        logic er;
        int len, nd, ne;
        f = frame(d, p, 1'b1, 1'b0, 1'b0, len);
        f[8] = f[8] ^ bad;
        er = bad & p[1];
        nd = n_rxd;
        ne = n_rxe;
        cfg(p, 1'b1, 1'b0, rxe);
        upt_remote_i.send(f, len, 1'b0);
        repeat (32) @(posedge ref_clk);
        check("rx done", nd + int'(rxe), n_rxd);
        check("rx error irq", ne + int'(er), n_rxe);
        rdc("rx err", `UPT_OFS_RXERR, {29'h0, er, 2'b00});
        rdc("rx buf", `UPT_OFS_RXBUF, eb);
    endtask
    task automatic t_rx();
        logic [11:0] f;
        int len;
        for (int p = 0; p < 4; p++)
            for (int b = 0; b < 2; b++)
                if (p > 0 || b == 0) rx_one(8'h3C + p[7:0], p[1:0], b[0], 1'b1, 8'h3C + p[7:0]);
        rx_one(8'hE7, UPT_PAR_NONE, 1'b0, 1'b0, 8'h3F);
        cfg(UPT_PAR_NONE, 1'b1, 1'b1, 1'b1);
        f = frame(8'h12, UPT_PAR_NONE, 1'b1, 1'b0, 1'b0, len);
        upt_remote_i.send(f, len, 1'b0);
        f = frame(8'h34, UPT_PAR_NONE, 1'b1, 1'b0, 1'b0, len);
        upt_remote_i.send(f, len, 1'b1);
        repeat (32) @(posedge ref_clk);
        rdc("overrun", `UPT_OFS_RXERR, 8'h01);
        rdc("kept buf", `UPT_OFS_RXBUF, 8'h12);
    endtask
    initial begin
        rstn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_tx();
        t_b2b();
        t_rx();
        complete_run();
    end
    initial begin
        #400_000;
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire

// ---- upt_defs.svh ----
// register offsets, field positions, reset values and bus response codes of the uart core
`ifndef UPT_DEFS_SVH
`define UPT_DEFS_SVH
`define UPT_OFS_MODE 5'h00
`define UPT_OFS_CTRL 5'h04
`define UPT_OFS_BAUD 5'h08
`define UPT_OFS_TXBUF 5'h0C
`define UPT_OFS_TXSTAT 5'h10
`define UPT_OFS_RXERR 5'h14
`define UPT_OFS_RXBUF 5'h18
`define UPT_MODE_RESET 8'h01
`define UPT_CTRL_RESET 8'h00
`define UPT_BAUD_RESET 8'hFF
`define UPT_RXBUF_RESET 8'hFF
`define UPT_BIT_POWER 7
`define UPT_BIT_TXE 6
`define UPT_BIT_RXE 5
`define UPT_BIT_PS1 4
`define UPT_BIT_PS0 3
`define UPT_BIT_CL 2
`define UPT_BIT_SL 1
`define UPT_BIT_ISRM 0
`define UPT_BIT_DIR 1
`define UPT_BIT_INV 0
`define UPT_BIT_BUF_FULL 1
`define UPT_BIT_SHIFT_BUSY 0
`define UPT_BIT_PARITY_ERR 2
`define UPT_BIT_FRAME_ERR 1
`define UPT_BIT_OVERRUN 0
`define UPT_RESP_OKAY 2'b00
`define UPT_RESP_SLVERR 2'b10
`endif

// ---- upt_pkg.sv ----
// types shared by the uart core
package upt_pkg;
    typedef enum logic [1:0] {
        UPT_PAR_NONE = 2'b00,
        UPT_PAR_ZERO = 2'b01,
        UPT_PAR_ODD = 2'b10,
        UPT_PAR_EVEN = 2'b11
    } upt_par_e;
    typedef enum logic [5:0] {
        UPT_S_IDLE = 6'b00_0001,
        UPT_S_START = 6'b00_0010,
        UPT_S_DATA = 6'b00_0100,
        UPT_S_PAR = 6'b00_1000,
        UPT_S_STOP = 6'b01_0000,
        UPT_S_STOP2 = 6'b10_0000
    } upt_state_e;
endpackage

// ---- upt_remote.sv ----
// remote serial node model: sends frames to the core and captures its frames
`timescale 1ns/100ps
`default_nettype none
module upt_remote (
    input wire logic ref_clk,
    input wire logic baud_tick,
    input wire logic line_in,
    output logic line_out
);
    int rx_len = 10;
    logic [11:0] rx_q[$];
    initial line_out = 1'b1;
    // bit edges sit half a bit from the tick, so the core samples mid-bit
    task automatic send(input logic [11:0] f, input int len, input bit now);
        if (!now) begin
            @(posedge ref_clk iff baud_tick);
            repeat (8) @(posedge ref_clk);
        end
        line_out <= 1'b0; // start, data, parity, stops
        for (int i = 0; i < len; i++) begin
            repeat (16) @(posedge ref_clk);
            line_out <= f[i];
        end
        // the stop bit leaves the line high, so a following send may start at once
        repeat (16) @(posedge ref_clk);
    endtask
    // captures the bits after a start, at mid-bit
    always begin : capture
        logic [11:0] f;
        f = 12'hFFF;
        @(negedge line_in);
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < rx_len; i++) begin
            repeat (16) @(posedge ref_clk);
            f[i] = line_in;
        end
        rx_q.push_back(f);
    end
endmodule
`default_nettype wire
